// *** src/bfsi_pkg.sv ***
// Package: constants and types for bus-fault safety and status indicators
package bfsi_pkg;

    // ==========================================
    // Clock and timing
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned LAMP_MS = 250;
    localparam int unsigned LAMP_CYC = (CLK_HZ / 1000) * LAMP_MS;
    localparam int unsigned DUP_CHECK_MS = 2000;
    localparam int unsigned DUP_CHECK_CYC = (CLK_HZ / 1000) * DUP_CHECK_MS;
    localparam int unsigned FLASH_MS = 500;
    localparam int unsigned FLASH_CYC = (CLK_HZ / 1000) * FLASH_MS;
    localparam int CNT_W = 32;

    // ==========================================
    // Configuration object addressing
    localparam logic [7:0] CFG_CLASS = 8'h96;
    localparam logic [7:0] CFG_INSTANCE = 8'h01;
    localparam logic [7:0] ATTR_PATTERN = 8'h06;
    localparam logic [7:0] ATTR_BEHAVIOUR = 8'h07;

    // ==========================================
    // Field layout and reset values
    localparam int BEHAV_HOLD_BIT = 0;
    localparam logic [7:0] BEHAVIOUR_RST = 8'h00;
    localparam logic [7:0] PATTERN_RST = 8'h00;
    localparam logic [7:0] PATTERN_MAX = 8'h03;

    // ==========================================
    // Explicit message answers
    localparam logic [7:0] SVC_OK = 8'h00;
    localparam logic [7:0] SVC_BAD_ATTR = 8'h14;
    localparam logic [7:0] SVC_BAD_VALUE = 8'h09;

    // Indicator colour codes on a two-wire green/red lamp
    typedef enum logic [1:0] {
        BFSI_LAMP_OFF,
        BFSI_LAMP_GREEN,
        BFSI_LAMP_RED
    } bfsi_lamp_t;

    typedef enum logic [2:0] {
        BFSI_PH_GREEN,
        BFSI_PH_RED,
        BFSI_PH_DUP,
        BFSI_PH_RUN
    } bfsi_phase_t;

endpackage : bfsi_pkg

// *** src/bfsi_sync.sv ***
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module bfsi_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] meta_nxt;
    logic [W-1:0] q_r;
    logic [W-1:0] q_nxt;

    always_comb begin
        meta_nxt = ce ? d : meta_r;
        q_nxt = ce ? meta_r : q_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_r <= '0;
            q_r <= '0;
        end else begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;
endmodule : bfsi_sync
`default_nettype wire

// *** src/bfsi_top.sv ***
// Bus-fault valve fallback, configuration attributes and status indicators
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - Behaviour byte: bit 0 picks safety pattern or hold; bits 1..7 read zero.
// - Pattern byte 0..3: all off, or only pilot one, two or three on.
// - Fallback pattern never energises more than one pilot.
// - Master reads and writes both bytes; device answers with stored values.
// - Both indicators show green 250 ms then red 250 ms after power-up.
// - New baud or address switch settings apply only after restart.
// - Network indicator off during duplicate address check or if it fails.
// - Network indicator steady green when online and connected.
// - Network indicator flashes green when online without connection.
// - Network indicator flashes red on I/O connection timeout.
// - Network indicator steady red on duplicate address or no communication.
// - Every indicated bus error is mirrored to the central indicator.
module bfsi_top #(
    parameter int unsigned LAMP_CYC = bfsi_pkg::LAMP_CYC,
    parameter int unsigned DUP_CHECK_CYC = bfsi_pkg::DUP_CHECK_CYC,
    parameter int unsigned FLASH_CYC = bfsi_pkg::FLASH_CYC
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic msg_valid,
    input wire logic msg_write,
    input wire logic [7:0] msg_class,
    input wire logic [7:0] msg_instance,
    input wire logic [7:0] msg_attr,
    input wire logic [7:0] msg_wdata,
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic [7:0] rsp_status,
    input wire logic [2:0] pilot_cmd,
    input wire logic bus_error,
    input wire logic dup_check_done,
    input wire logic dup_check_fail,
    input wire logic dup_mac_found,
    input wire logic bus_comm_lost,
    input wire logic master_connected,
    input wire logic io_timeout,
    input wire logic [7:0] switch_pins,
    output logic [2:0] pilot_out,
    output logic [7:0] active_switches,
    output logic module_green,
    output logic module_red,
    output logic network_green,
    output logic network_red,
    output logic central_multicolour_indicator
);

    // ==========================================
    // Switch pins cross into the clock domain
    logic [7:0] sw_sync;

    bfsi_sync #(.W(8)) u_sw_sync (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .d(switch_pins),
        .q(sw_sync)
    );

    // ==========================================
    // Pattern decode for the valve fallback path
    function automatic logic [2:0] pattern_to_pilots(input logic [7:0] pat);
        logic [2:0] p;
        p = 3'h0;
        case (pat)
            8'h01: p = 3'h1;
            8'h02: p = 3'h2;
            8'h03: p = 3'h4;
            default: p = 3'h0;
        endcase
        return p;
    endfunction : pattern_to_pilots

    // ==========================================
    // Configuration attributes and explicit messages
    logic [7:0] behaviour_r;
    logic [7:0] behaviour_nxt;
    logic [7:0] pattern_r;
    logic [7:0] pattern_nxt;
    logic rsp_valid_r;
    logic rsp_valid_nxt;
    logic [7:0] rsp_data_r;
    logic [7:0] rsp_data_nxt;
    logic [7:0] rsp_status_r;
    logic [7:0] rsp_status_nxt;
    logic obj_hit;

    always_comb begin
        behaviour_nxt = behaviour_r;
        pattern_nxt = pattern_r;
        rsp_valid_nxt = 1'b0;
        rsp_data_nxt = rsp_data_r;
        rsp_status_nxt = rsp_status_r;
        obj_hit = (msg_class == bfsi_pkg::CFG_CLASS) &&
                  (msg_instance == bfsi_pkg::CFG_INSTANCE);
        if (msg_valid) begin
            rsp_valid_nxt = 1'b1;
            rsp_data_nxt = 8'h00;
            rsp_status_nxt = bfsi_pkg::SVC_OK;
            if (obj_hit && msg_attr == bfsi_pkg::ATTR_BEHAVIOUR) begin
                if (msg_write) begin
                    // Only bit 0 is stored so the upper bits always read zero
                    behaviour_nxt = {7'h00, msg_wdata[0]};
                    rsp_data_nxt = {7'h00, msg_wdata[0]};
                end else begin
                    rsp_data_nxt = behaviour_r;
                end
            end else if (obj_hit && msg_attr == bfsi_pkg::ATTR_PATTERN) begin
                if (msg_write) begin
                    // Values above 3 would be undefined pilot sets, so refuse them
                    if (msg_wdata > bfsi_pkg::PATTERN_MAX) begin
                        rsp_status_nxt = bfsi_pkg::SVC_BAD_VALUE;
                        rsp_data_nxt = pattern_r;
                    end else begin
                        pattern_nxt = msg_wdata;
                        rsp_data_nxt = msg_wdata;
                    end
                end else begin
                    rsp_data_nxt = pattern_r;
                end
            end else begin
                rsp_status_nxt = bfsi_pkg::SVC_BAD_ATTR;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            behaviour_r <= bfsi_pkg::BEHAVIOUR_RST;
            pattern_r <= bfsi_pkg::PATTERN_RST;
            rsp_valid_r <= 1'b0;
            rsp_data_r <= 8'h00;
            rsp_status_r <= 8'h00;
        end else if (ce) begin
            behaviour_r <= behaviour_nxt;
            pattern_r <= pattern_nxt;
            rsp_valid_r <= rsp_valid_nxt;
            rsp_data_r <= rsp_data_nxt;
            rsp_status_r <= rsp_status_nxt;
        end
    end

    // ==========================================
    // Pilot valve outputs
    logic [2:0] pilot_r;
    logic [2:0] pilot_nxt;

    always_comb begin
        pilot_nxt = pilot_cmd;
        if (bus_error) begin
            if (behaviour_r[bfsi_pkg::BEHAV_HOLD_BIT]) begin
                pilot_nxt = pilot_r;
            end else begin
                pilot_nxt = pattern_to_pilots(pattern_r);
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pilot_r <= 3'h0;
        end else if (ce) begin
            pilot_r <= pilot_nxt;
        end
    end

    // ==========================================
    // Switch capture at restart
    // Captured on the first enabled cycle after the synchroniser has filled
    logic [7:0] active_sw_r;
    logic [7:0] active_sw_nxt;
    logic [1:0] cap_wait_r;
    logic [1:0] cap_wait_nxt;
    logic sw_changed_r;
    logic sw_changed_nxt;

    always_comb begin
        active_sw_nxt = active_sw_r;
        cap_wait_nxt = cap_wait_r;
        sw_changed_nxt = 1'b0;
        if (cap_wait_r != 2'h3) begin
            cap_wait_nxt = cap_wait_r + 2'h1;
            if (cap_wait_r == 2'h2) begin
                active_sw_nxt = sw_sync;
            end
        end else begin
            sw_changed_nxt = (sw_sync != active_sw_r);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            active_sw_r <= 8'h00;
            cap_wait_r <= 2'h0;
            sw_changed_r <= 1'b0;
        end else if (ce) begin
            active_sw_r <= active_sw_nxt;
            cap_wait_r <= cap_wait_nxt;
            sw_changed_r <= sw_changed_nxt;
        end
    end

    // ==========================================
    // Power-up lamp test, duplicate address check and flash timebase
    bfsi_pkg::bfsi_phase_t phase_r;
    bfsi_pkg::bfsi_phase_t phase_nxt;
    logic [bfsi_pkg::CNT_W-1:0] tmr_r;
    logic [bfsi_pkg::CNT_W-1:0] tmr_nxt;
    logic [bfsi_pkg::CNT_W-1:0] flash_cnt_r;
    logic [bfsi_pkg::CNT_W-1:0] flash_cnt_nxt;
    logic blink_r;
    logic blink_nxt;
    logic dup_failed_r;
    logic dup_failed_nxt;

    always_comb begin
        phase_nxt = phase_r;
        tmr_nxt = tmr_r + 32'h0000_0001;
        dup_failed_nxt = dup_failed_r;
        flash_cnt_nxt = flash_cnt_r + 32'h0000_0001;
        blink_nxt = blink_r;
        if (flash_cnt_r >= FLASH_CYC - 1) begin
            flash_cnt_nxt = 32'h0000_0000;
            blink_nxt = ~blink_r;
        end
        case (phase_r)
            bfsi_pkg::BFSI_PH_GREEN: begin
                if (tmr_r >= LAMP_CYC - 1) begin
                    phase_nxt = bfsi_pkg::BFSI_PH_RED;
                    tmr_nxt = 32'h0000_0000;
                end
            end
            bfsi_pkg::BFSI_PH_RED: begin
                if (tmr_r >= LAMP_CYC - 1) begin
                    phase_nxt = bfsi_pkg::BFSI_PH_DUP;
                    tmr_nxt = 32'h0000_0000;
                end
            end
            bfsi_pkg::BFSI_PH_DUP: begin
                // A check that never ends keeps the network lamp dark
                if (dup_check_fail) begin
                    dup_failed_nxt = 1'b1;
                end else if ((dup_check_done || dup_mac_found) && !dup_failed_r) begin
                    phase_nxt = bfsi_pkg::BFSI_PH_RUN;
                end
                if (tmr_r >= DUP_CHECK_CYC - 1) begin
                    tmr_nxt = tmr_r;
                end
            end
            default: begin
                tmr_nxt = tmr_r;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            phase_r <= bfsi_pkg::BFSI_PH_GREEN;
            tmr_r <= 32'h0000_0000;
            flash_cnt_r <= 32'h0000_0000;
            blink_r <= 1'b0;
            dup_failed_r <= 1'b0;
        end else if (ce) begin
            phase_r <= phase_nxt;
            tmr_r <= tmr_nxt;
            flash_cnt_r <= flash_cnt_nxt;
            blink_r <= blink_nxt;
            dup_failed_r <= dup_failed_nxt;
        end
    end

    // ==========================================
    // Indicator drive
    logic mod_g_r;
    logic mod_g_nxt;
    logic mod_r_r;
    logic mod_r_nxt;
    logic net_g_r;
    logic net_g_nxt;
    logic net_r_r;
    logic net_r_nxt;
    logic central_r;
    logic central_nxt;

    always_comb begin
        mod_g_nxt = 1'b0;
        mod_r_nxt = 1'b0;
        net_g_nxt = 1'b0;
        net_r_nxt = 1'b0;
        case (phase_r)
            bfsi_pkg::BFSI_PH_GREEN: begin
                mod_g_nxt = 1'b1;
                net_g_nxt = 1'b1;
            end
            bfsi_pkg::BFSI_PH_RED: begin
                mod_r_nxt = 1'b1;
                net_r_nxt = 1'b1;
            end
            bfsi_pkg::BFSI_PH_DUP: begin
                mod_g_nxt = ~sw_changed_r;
                mod_r_nxt = sw_changed_r & blink_r;
            end
            default: begin
                mod_g_nxt = ~sw_changed_r;
                mod_r_nxt = sw_changed_r & blink_r;
                // Critical faults outrank timeouts, which outrank connection state
                if (dup_mac_found || bus_comm_lost) begin
                    net_r_nxt = 1'b1;
                end else if (io_timeout) begin
                    net_r_nxt = blink_r;
                end else if (master_connected) begin
                    net_g_nxt = 1'b1;
                end else begin
                    net_g_nxt = blink_r;
                end
            end
        endcase
        // Any error state on either lamp lights the central fault colour
        central_nxt = (phase_r == bfsi_pkg::BFSI_PH_RUN &&
                       (dup_mac_found || bus_comm_lost || io_timeout)) ||
                      sw_changed_r || dup_failed_r;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mod_g_r <= 1'b0;
            mod_r_r <= 1'b0;
            net_g_r <= 1'b0;
            net_r_r <= 1'b0;
            central_r <= 1'b0;
        end else if (ce) begin
            mod_g_r <= mod_g_nxt;
            mod_r_r <= mod_r_nxt;
            net_g_r <= net_g_nxt;
            net_r_r <= net_r_nxt;
            central_r <= central_nxt;
        end
    end

    assign rsp_valid = rsp_valid_r;
    assign rsp_data = rsp_data_r;
    assign rsp_status = rsp_status_r;
    assign pilot_out = pilot_r;
    assign active_switches = active_sw_r;
    assign module_green = mod_g_r;
    assign module_red = mod_r_r;
    assign network_green = net_g_r;
    assign network_red = net_r_r;
    assign central_multicolour_indicator = central_r;

endmodule : bfsi_top
`default_nettype wire

// *** verification/bfsi_chk_assertions.sv ***
// Port-level checks for the bus-fault indicator block
`timescale 1ns/1ps
`default_nettype none
module bfsi_chk #(
    parameter int unsigned LAMP_CYC = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    input wire logic msg_valid,
    input wire logic [7:0] msg_class,
    input wire logic [7:0] msg_instance,
    input wire logic [7:0] msg_attr,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic bus_error,
    input wire logic dup_mac_found,
    input wire logic bus_comm_lost,
    input wire logic [2:0] pilot_out,
    input wire logic [7:0] active_switches,
    input wire logic module_green,
    input wire logic module_red,
    input wire logic network_green,
    input wire logic network_red,
    input wire logic central_multicolour_indicator
);
    // ==========================================
    // Enabled edges since reset, saturating past the lamp test
    int unsigned cnt_r;
    int unsigned cnt_nxt;
    always_comb begin
        cnt_nxt = cnt_r;
        if (ce && cnt_r < 2 * LAMP_CYC + 2) begin
            cnt_nxt = cnt_r + 1;
        end
    end
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cnt_r <= 0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
    wire logic run = cnt_r > 2 * LAMP_CYC;
    wire logic get_beh = ce && msg_valid && msg_class == 8'h96 && msg_instance == 8'h01
        && msg_attr == 8'h07;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    sequence s_green;
        module_green && network_green && !module_red && !network_red;
    endsequence
    sequence s_red;
        !module_green && !network_green && module_red && network_red;
    endsequence
    a_lamp_green: assert property (cnt_r >= 1 && cnt_r <= LAMP_CYC |-> s_green)
        else $error("lamp test green wrong");
    a_lamp_red: assert property (cnt_r > LAMP_CYC && cnt_r <= 2 * LAMP_CYC |-> s_red)
        else $error("lamp test red wrong");
    a_dup_off: assert property (cnt_r == 2 * LAMP_CYC + 1
        |-> !network_green && !network_red)
        else $error("network lit in address check");
    a_rsp_taken: assert property (ce && msg_valid |=> rsp_valid)
        else $error("no answer to message");
    a_behav_upper: assert property (get_beh |=> rsp_data[7:1] == 7'h00)
        else $error("behaviour upper bits set");
    a_fallback_one: assert property (ce && bus_error
        |=> $onehot0(pilot_out) || $stable(pilot_out))
        else $error("more than one pilot on");
    a_crit_red: assert property (run && (network_green || network_red)
        && (dup_mac_found || bus_comm_lost) |=> network_red && !network_green)
        else $error("critical fault not steady red");
    a_red_mirror: assert property (run && network_red
        |-> central_multicolour_indicator)
        else $error("fault not on central indicator");
    a_switch_hold: assert property (cnt_r > 3 |-> $stable(active_switches))
        else $error("switch values changed without restart");
endmodule : bfsi_chk
`default_nettype wire

// *** verification/bfsi_master.sv ***
// Behavioural fieldbus master issuing explicit messages
`timescale 1ns/1ps
`default_nettype none
module bfsi_master (
    input wire logic clk,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic [7:0] rsp_status,
    output logic msg_valid,
    output logic msg_write,
    output logic [7:0] msg_class,
    output logic [7:0] msg_instance,
    output logic [7:0] msg_attr,
    output logic [7:0] msg_wdata,
    output logic master_connected
);
    logic got_ok;
    logic [7:0] got_data;
    logic [7:0] got_status;
    initial begin
        msg_valid = 1'b0;
        {msg_write, msg_class, msg_instance, msg_attr, msg_wdata} = '0;
        master_connected = 1'b0;
    end
    // ==========================================
    // Get or set one attribute; released fields show inverted junk
    task automatic xfer(input logic wr, input logic [7:0] cls, input logic [7:0] attr,
        input logic [7:0] wd, input int gap);
        repeat (gap + 1) @(posedge clk);
        #1;
        msg_valid = 1'b1;
        {msg_write, msg_class, msg_instance, msg_attr, msg_wdata} = {wr, cls, 8'h01, attr, wd};
        @(posedge clk);
        #1;
        got_ok = rsp_valid;
        got_data = rsp_data;
        got_status = rsp_status;
        msg_valid = 1'b0;
        {msg_write, msg_class, msg_instance, msg_attr, msg_wdata} = ~{wr, cls, 8'h01, attr, wd};
    endtask : xfer
    // Connection set up or dropped, or set up again after an I/O time-out
    task automatic connect(input logic on);
        @(posedge clk);
        #1;
        master_connected = on;
    endtask : connect
endmodule : bfsi_master
`default_nettype wire

// *** verification/tb_bfsi_top.sv ***
// Self-checking bench for the bus-fault indicator block
`timescale 1ns/1ps
`default_nettype none
module tb_bfsi_top;
    localparam int LC = 8;
    logic clk, reset, ce, msg_valid, msg_write, rsp_valid, bus_error, dup_check_done;
    logic dup_check_fail, dup_mac_found, bus_comm_lost, master_connected, io_timeout;
    logic module_green, module_red, network_green, network_red, central_multicolour_indicator;
    logic [7:0] msg_class, msg_instance, msg_attr, msg_wdata, rsp_data, rsp_status;
    logic [7:0] switch_pins, active_switches;
    logic [2:0] pilot_cmd, pilot_out, v;
    logic [31:0] seed = 32'h0000_0029;
    logic [31:0] r;
    int err_total = 0;
    int n_tests = 0;
    int beh, pat;
    int cnt [5];
    bfsi_top #(.LAMP_CYC(LC), .DUP_CHECK_CYC(16), .FLASH_CYC(4)) dut (.clk, .reset, .ce,
        .msg_valid, .msg_write, .msg_class, .msg_instance, .msg_attr, .msg_wdata, .rsp_valid,
        .rsp_data, .rsp_status, .pilot_cmd, .bus_error, .dup_check_done, .dup_check_fail,
        .dup_mac_found, .bus_comm_lost, .master_connected, .io_timeout, .switch_pins,
        .pilot_out, .active_switches, .module_green, .module_red, .network_green,
        .network_red, .central_multicolour_indicator);
    bfsi_master m (.clk, .rsp_valid, .rsp_data, .rsp_status, .msg_valid, .msg_write,
        .msg_class, .msg_instance, .msg_attr, .msg_wdata, .master_connected);
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================
    // Shared tasks
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic access(input logic wr, input logic [7:0] cls, input logic [7:0] attr,
        input logic [7:0] wd);
        logic [7:0] es;
        es = 8'h00;
        if (cls != 8'h96 || (attr != 8'h06 && attr != 8'h07)) es = 8'h14;
        else if (wr && attr == 8'h07) beh = wd[0];
        else if (wr && wd > 8'h03) es = 8'h09;
        else if (wr) pat = wd;
        m.xfer(wr, cls, attr, wd, int'(seed[1:0]));
        chk({7'h00, m.got_ok}, 8'h01);
        chk(m.got_status, es);
        if (es != 8'h14) chk(m.got_data, (attr == 8'h07) ? 8'(beh) : 8'(pat));
    endtask : access
    task automatic do_reset();
        reset = 1'b1;
        beh = 0;
        pat = 0;
        repeat (2) @(posedge clk);
        #1;
        reset = 1'b0;
        for (int k = 1; k <= 2 * LC + 1; k++) begin
            @(posedge clk);
            #1;
            if (k <= 2 * LC) chk({4'h0, module_green, module_red, network_green, network_red},
                (k <= LC) ? 8'h0a : 8'h05);
            else chk({6'h00, network_green, network_red}, 8'h00);
        end
        $display("test reset and lamp done");
    endtask : do_reset
    // Counts lit cycles of network green, network red, module green, module red, central
    task automatic watch(input int n);
        cnt = '{default: 0};
        repeat (4) @(posedge clk);
        repeat (n) begin
            @(posedge clk);
            #1;
            cnt[0] += network_green;
            cnt[1] += network_red;
            cnt[2] += module_green;
            cnt[3] += module_red;
            cnt[4] += central_multicolour_indicator;
        end
    endtask : watch
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5000) @(posedge clk);
        err_total++;
        final_report();
    end
    // ==========================================
    // Main sequence
    initial begin
        {ce, bus_error, dup_check_done, dup_check_fail, dup_mac_found} = 5'h10;
        {bus_comm_lost, io_timeout, pilot_cmd} = 5'h00;
        switch_pins = 8'h5a;
        do_reset();
        access(1'b0, 8'h96, 8'h06, 8'h00);
        access(1'b1, 8'h96, 8'h06, 8'h07);
        for (int i = 0; i < 16; i++) begin
            r = xs();
            access(r[0], (i == 5) ? 8'h95 : 8'h96, 8'h05 + {6'h00, r[2:1]},
                r[3] ? r[15:8] : {5'h00, r[6:4]});
        end
        $display("test config done");
        for (int p = 0; p < 4; p++) begin
            access(1'b1, 8'h96, 8'h06, 8'(p));
            access(1'b1, 8'h96, 8'h07, 8'h00);
            r = xs();
            bus_error = 1'b1;
            pilot_cmd = r[2:0];
            @(posedge clk);
            #1;
            chk({5'h00, pilot_out},
                (p == 0) ? 8'h00 : 8'h01 << (p - 1));
            bus_error = 1'b0;
        end
        r = xs();
        v = r[2:0];
        pilot_cmd = v;
        access(1'b1, 8'h96, 8'h07, 8'hff);
        bus_error = 1'b1;
        pilot_cmd = ~v;
        repeat (3) @(posedge clk);
        #1;
        chk({5'h00, pilot_out}, {5'h00, v});
        // Clock enable low must freeze the held outputs even once the error clears
        ce = 1'b0;
        bus_error = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk({5'h00, pilot_out}, {5'h00, v});
        ce = 1'b1;
        @(posedge clk);
        #1;
        chk({5'h00, pilot_out}, {5'h00, ~v});
        $display("test fallback done");
        dup_check_done = 1'b1;
        m.connect(1'b1);
        watch(8);
        chk({cnt[0][3:0], cnt[4][3:0]}, 8'h80);
        m.connect(1'b0);
        watch(8);
        chk({cnt[0][3:0], cnt[1][3:0]}, 8'h40);
        io_timeout = 1'b1;
        watch(8);
        chk({cnt[0][3:0], cnt[1][3:0]}, 8'h04);
        chk(cnt[4][7:0], 8'h08);
        io_timeout = 1'b0;
        m.connect(1'b1);
        for (int k = 0; k < 2; k++) begin
            {dup_mac_found, bus_comm_lost} = k ? 2'h1 : 2'h2;
            watch(8);
            chk({cnt[0][3:0], cnt[1][3:0]}, 8'h08);
            chk({cnt[2][3:0], cnt[4][3:0]}, 8'h88);
        end
        {dup_mac_found, bus_comm_lost} = 2'h0;
        $display("test network done");
        switch_pins = 8'ha5;
        watch(8);
        chk({cnt[2][3:0], cnt[3][3:0]}, 8'h04);
        chk(cnt[4][7:0], 8'h08);
        chk(active_switches, 8'h5a);
        dup_check_done = 1'b0;
        do_reset();
        chk(active_switches, 8'ha5);
        {dup_check_fail, dup_check_done} = 2'h3;
        watch(8);
        chk({cnt[0][3:0], cnt[1][3:0]}, 8'h00);
        chk(cnt[4][7:0], 8'h08);
        // A failed check stays latched even once the fail input drops
        dup_check_fail = 1'b0;
        watch(8);
        chk({cnt[0][3:0], cnt[1][3:0]}, 8'h00);
        access(1'b0, 8'h96, 8'h07, 8'h00);
        $display("test restart done");
        final_report();
    end
endmodule : tb_bfsi_top
bind bfsi_top bfsi_chk #(.LAMP_CYC(LAMP_CYC)) u_chk (.clk, .reset, .ce, .msg_valid,
    .msg_class, .msg_instance, .msg_attr, .rsp_valid, .rsp_data, .bus_error, .dup_mac_found,
    .bus_comm_lost, .pilot_out, .active_switches, .module_green, .module_red, .network_green,
    .network_red, .central_multicolour_indicator);
`default_nettype wire
